//--- mtc_pkg.sv
// constants for the machine trap register unit
`default_nettype none
package mtc_pkg;
  // register addresses
  localparam logic [11:0] ADDR_STATUS = 12'h300;
  localparam logic [11:0] ADDR_COUNTER_EN = 12'h306;
  localparam logic [11:0] ADDR_STATUS_HIGH = 12'h310;
  localparam logic [11:0] ADDR_SCRATCH = 12'h340;
  localparam logic [11:0] ADDR_RETURN_PC = 12'h341;
  localparam logic [11:0] ADDR_CAUSE = 12'h342;
  localparam logic [11:0] ADDR_VALUE = 12'h343;
  localparam logic [11:0] ADDR_PENDING = 12'h344;
  // performance monitor counter windows, index 3..31 of each
  localparam logic [6:0] PMC_USER_LO = 7'h60;
  localparam logic [6:0] PMC_USER_HI = 7'h64;
  localparam logic [6:0] PMC_MACH_LO = 7'h58;
  localparam logic [6:0] PMC_MACH_HI = 7'h5C;
  localparam logic [6:0] PMC_EVENT = 7'h19;
  localparam logic [4:0] PMC_FIRST = 5'h03;
  // field positions
  localparam int BIT_GIE = 3;
  localparam int BIT_PGIE = 7;
  localparam int BIT_SOFT = 3;
  localparam int BIT_TIMER = 7;
  localparam int BIT_EXT = 11;
  localparam int FAST_LO = 16;
  localparam int FAST_N = 16;
  localparam int CAUSE_IRQ = 31;
  localparam int CAUSE_ID_W = 5;
  localparam int CNT_EN_W = 3;
  // reset values
  localparam logic [31:0] STATUS_HIGH_VAL = 32'h0000_0000;
  localparam logic [31:0] PENDING_RST = 32'h0000_0000;
  localparam logic [CNT_EN_W-1:0] CNT_EN_RST = 3'h0;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  // trap identifiers
  localparam logic [4:0] ID_FETCH_MISALIGN = 5'h00;
  localparam logic [4:0] ID_FETCH_FAULT = 5'h01;
  localparam logic [4:0] ID_ILLEGAL = 5'h02;
  localparam logic [4:0] ID_LOAD_MISALIGN = 5'h04;
  localparam logic [4:0] ID_LOAD_FAULT = 5'h05;
  localparam logic [4:0] ID_STORE_MISALIGN = 5'h06;
  localparam logic [4:0] ID_STORE_FAULT = 5'h07;
endpackage
`default_nettype wire

//--- mtc_latch_bit.sv
// one sticky pending flag, set beats clear
`timescale 1ns/10ps
`default_nettype none
module mtc_latch_bit (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // control
  input wire logic set_req,
  input wire logic clr_req,
  // state
  output logic flag
);
  logic flag_reg;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      flag_reg <= 1'b0;
    end else if (set_req) begin
      flag_reg <= 1'b1;
    end else if (clr_req) begin
      flag_reg <= 1'b0;
    end
  end

  assign flag = flag_reg;
endmodule
`default_nettype wire

//--- mtc_value_sel.sv
// chooses the trap value word from the trap cause
`timescale 1ns/10ps
`default_nettype none
module mtc_value_sel (
  // trap description
  input wire logic is_irq,
  input wire logic [4:0] trap_id,
  input wire logic [31:0] fetch_addr,
  input wire logic [31:0] fault_pc,
  input wire logic [31:0] fault_instr,
  // result
  output logic [31:0] value
);
  always_comb begin
    value = mtc_pkg::ZERO_WORD;
    if (!is_irq) begin
      unique case (trap_id)
        mtc_pkg::ID_FETCH_MISALIGN,
        mtc_pkg::ID_FETCH_FAULT: begin
          value = fetch_addr;
        end
        mtc_pkg::ID_LOAD_MISALIGN,
        mtc_pkg::ID_LOAD_FAULT,
        mtc_pkg::ID_STORE_MISALIGN,
        mtc_pkg::ID_STORE_FAULT: begin
          value = fault_pc;
        end
        mtc_pkg::ID_ILLEGAL: begin
          value = fault_instr;
        end
        default: begin
          value = mtc_pkg::ZERO_WORD;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

//--- mtc_trap_unit.sv
// machine trap registers, pending flags and counter access check
//
// Overview of operation
// - counter enable bits 31:3 always zero; user never reads perf counters
// - any access to performance counter registers raises illegal instruction
// - status high word 0x310 reads zero, read-only, writes ignored
// - scratch 0x340 is plain 32-bit read/write storage, no reset
// - exception loads return pc with the faulting instruction address
// - interrupt loads return pc with next not-yet-executed address
// - cause bit 31 set for interrupt, cleared for exception
// - cause bits 4:0 hold trap id; bits 30:5 read zero
// - fetch misalign or fetch fault stores the fetch address as value
// - load or store misalign or fault stores faulting pc as value
// - illegal instruction stores the expanded 32-bit instruction word
// - all other causes, interrupts too, store zero as value
// - trap value writes are ignored and raise no exception
// - pending resets zero; standard bits read-only, cleared at source
// - fast lines latch into bits 31:16 until software clears them
// - external request at bit 11, software request at bit 3
// - bit 7 follows timer request, cleared only by timer compare
// - trap entry saves then clears global enable; return restores it
`timescale 1ns/10ps
`default_nettype none
module mtc_trap_unit (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // register access from the pipeline
  input wire logic csr_valid,
  input wire logic csr_write,
  input wire logic [11:0] csr_addr,
  input wire logic [31:0] csr_wdata,
  output logic csr_ack,
  output logic csr_hit,
  output logic csr_illegal,
  output logic [31:0] csr_rdata,
  // trap entry and return
  input wire logic trap_take,
  input wire logic trap_is_irq,
  input wire logic [4:0] trap_id,
  input wire logic [31:0] trap_pc,
  input wire logic [31:0] trap_next_pc,
  input wire logic [31:0] trap_fetch_addr,
  input wire logic [31:0] trap_instr,
  input wire logic trap_return,
  // interrupt requests
  input wire logic ext_irq,
  input wire logic timer_irq,
  input wire logic soft_irq,
  input wire logic [15:0] fast_irq,
  // state to the pipeline
  output logic irq_enable,
  output logic previous_irq_enable,
  output logic [31:0] irq_pending,
  output logic [31:0] trap_return_pc,
  output logic [2:0] counter_enable
);
  logic gie_reg;
  logic pgie_reg;
  logic [2:0] cnt_en_reg;
  logic [31:0] scratch_reg;
  logic [31:0] return_pc_reg;
  logic cause_irq_reg;
  logic [4:0] cause_id_reg;
  logic [31:0] value_reg;
  logic ext_pending_reg;
  logic timer_pending_reg;
  logic soft_pending_reg;
  logic [15:0] fast_pending;
  logic [31:0] value_next;
  logic [31:0] rdata_next;
  logic hit_next;
  logic pmc_access;
  logic wr_en;
  logic pending_wr;
  logic [31:0] cause_word;
  logic [31:0] pending_word;
  logic [31:0] status_word;

  // write strobe for the addressed register
  assign wr_en = csr_valid && csr_write;
  assign pending_wr = wr_en && csr_addr == mtc_pkg::ADDR_PENDING;

  // performance counters, their high words and event selectors
  always_comb begin
    pmc_access = 1'b0;
    if (csr_addr[4:0] >= mtc_pkg::PMC_FIRST) begin
      if (csr_addr[11:5] == mtc_pkg::PMC_USER_LO ||
          csr_addr[11:5] == mtc_pkg::PMC_USER_HI ||
          csr_addr[11:5] == mtc_pkg::PMC_MACH_LO ||
          csr_addr[11:5] == mtc_pkg::PMC_MACH_HI ||
          csr_addr[11:5] == mtc_pkg::PMC_EVENT) begin
        pmc_access = 1'b1;
      end
    end
  end

  // global and previous interrupt enable
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      gie_reg <= 1'b0;
      pgie_reg <= 1'b0;
    end else if (trap_take) begin
      pgie_reg <= gie_reg;
      gie_reg <= 1'b0;
    end else if (trap_return) begin
      gie_reg <= pgie_reg;
    end else if (wr_en && csr_addr == mtc_pkg::ADDR_STATUS) begin
      gie_reg <= csr_wdata[mtc_pkg::BIT_GIE];
      pgie_reg <= csr_wdata[mtc_pkg::BIT_PGIE];
    end
  end

  // user counter access enable, upper bits never stored
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cnt_en_reg <= mtc_pkg::CNT_EN_RST;
    end else if (wr_en && csr_addr == mtc_pkg::ADDR_COUNTER_EN) begin
      cnt_en_reg <= csr_wdata[mtc_pkg::CNT_EN_W-1:0];
    end
  end

  // scratch word, left unreset
  always_ff @(posedge core_clk) begin
    if (wr_en && csr_addr == mtc_pkg::ADDR_SCRATCH) begin
      scratch_reg <= csr_wdata;
    end
  end

  // return pc: trap entry beats a software write
  always_ff @(posedge core_clk) begin
    if (trap_take) begin
      if (trap_is_irq) begin
        return_pc_reg <= trap_next_pc;
      end else begin
        return_pc_reg <= trap_pc;
      end
    end else if (wr_en && csr_addr == mtc_pkg::ADDR_RETURN_PC) begin
      return_pc_reg <= csr_wdata;
    end
  end

  // cause: only the flag and the id are stored
  always_ff @(posedge core_clk) begin
    if (trap_take) begin
      cause_irq_reg <= trap_is_irq;
      cause_id_reg <= trap_id;
    end else if (wr_en && csr_addr == mtc_pkg::ADDR_CAUSE) begin
      cause_irq_reg <= csr_wdata[mtc_pkg::CAUSE_IRQ];
      cause_id_reg <= csr_wdata[mtc_pkg::CAUSE_ID_W-1:0];
    end
  end

  mtc_value_sel u_value_sel (
    .is_irq(trap_is_irq),
    .trap_id(trap_id),
    .fetch_addr(trap_fetch_addr),
    .fault_pc(trap_pc),
    .fault_instr(trap_instr),
    .value(value_next)
  );

  // trap value, written by hardware only
  always_ff @(posedge core_clk) begin
    if (trap_take) begin
      value_reg <= value_next;
    end
  end

  // standard requests mirrored, never written by software
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ext_pending_reg <= 1'b0;
      timer_pending_reg <= 1'b0;
      soft_pending_reg <= 1'b0;
    end else begin
      ext_pending_reg <= ext_irq;
      timer_pending_reg <= timer_irq;
      soft_pending_reg <= soft_irq;
    end
  end

  // fast lines: a zero written to a bit clears it
  genvar gi;
  generate
    for (gi = 0; gi < mtc_pkg::FAST_N; gi++) begin : g_fast
      mtc_latch_bit u_bit (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .set_req(fast_irq[gi]),
        .clr_req(pending_wr && !csr_wdata[mtc_pkg::FAST_LO + gi]),
        .flag(fast_pending[gi])
      );
    end
  endgenerate

  // assembled words
  always_comb begin
    status_word = mtc_pkg::ZERO_WORD;
    status_word[mtc_pkg::BIT_GIE] = gie_reg;
    status_word[mtc_pkg::BIT_PGIE] = pgie_reg;
    cause_word = mtc_pkg::ZERO_WORD;
    cause_word[mtc_pkg::CAUSE_IRQ] = cause_irq_reg;
    cause_word[mtc_pkg::CAUSE_ID_W-1:0] = cause_id_reg;
    pending_word = mtc_pkg::PENDING_RST;
    pending_word[mtc_pkg::BIT_EXT] = ext_pending_reg;
    pending_word[mtc_pkg::BIT_TIMER] = timer_pending_reg;
    pending_word[mtc_pkg::BIT_SOFT] = soft_pending_reg;
    pending_word[31:mtc_pkg::FAST_LO] = fast_pending;
  end

  // read multiplexer
  always_comb begin
    rdata_next = mtc_pkg::ZERO_WORD;
    hit_next = 1'b1;
    unique case (csr_addr)
      mtc_pkg::ADDR_STATUS: begin
        rdata_next = status_word;
      end
      mtc_pkg::ADDR_COUNTER_EN: begin
        rdata_next = {29'h0000_0000, cnt_en_reg};
      end
      mtc_pkg::ADDR_STATUS_HIGH: begin
        rdata_next = mtc_pkg::STATUS_HIGH_VAL;
      end
      mtc_pkg::ADDR_SCRATCH: begin
        rdata_next = scratch_reg;
      end
      mtc_pkg::ADDR_RETURN_PC: begin
        rdata_next = return_pc_reg;
      end
      mtc_pkg::ADDR_CAUSE: begin
        rdata_next = cause_word;
      end
      mtc_pkg::ADDR_VALUE: begin
        rdata_next = value_reg;
      end
      mtc_pkg::ADDR_PENDING: begin
        rdata_next = pending_word;
      end
      default: begin
        hit_next = pmc_access;
      end
    endcase
  end

  // registered answer one cycle after the request
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      csr_ack <= 1'b0;
      csr_hit <= 1'b0;
      csr_illegal <= 1'b0;
      csr_rdata <= mtc_pkg::ZERO_WORD;
    end else begin
      csr_ack <= csr_valid;
      csr_hit <= csr_valid && hit_next;
      csr_illegal <= csr_valid && pmc_access;
      csr_rdata <= csr_valid ? rdata_next : mtc_pkg::ZERO_WORD;
    end
  end

  assign irq_enable = gie_reg;
  assign previous_irq_enable = pgie_reg;
  assign irq_pending = pending_word;
  assign trap_return_pc = return_pc_reg;
  assign counter_enable = cnt_en_reg;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  cnt_en_upper_a: assert property (
    csr_valid && csr_addr == mtc_pkg::ADDR_COUNTER_EN
    |=> csr_rdata[31:3] == 29'h0000_0000 && !csr_illegal)
    else $error("counter enable upper bits not zero");

  pmc_illegal_a: assert property (
    csr_valid && pmc_access |=> csr_ack && csr_illegal)
    else $error("counter access not flagged illegal");

  status_high_a: assert property (
    csr_valid && csr_addr == mtc_pkg::ADDR_STATUS_HIGH
    |=> csr_rdata == 32'h0000_0000 && csr_hit && !csr_illegal)
    else $error("status high word not zero");

  scratch_keep_a: assert property (
    wr_en && csr_addr == mtc_pkg::ADDR_SCRATCH ##1 !wr_en
    ##1 (csr_valid && !csr_write && csr_addr == mtc_pkg::ADDR_SCRATCH)
    |=> csr_rdata == $past(csr_wdata, 3))
    else $error("scratch lost its data");

  epc_exception_a: assert property (
    trap_take && !trap_is_irq |=> return_pc_reg == $past(trap_pc))
    else $error("return pc wrong on exception");

  epc_interrupt_a: assert property (
    trap_take && trap_is_irq |=> return_pc_reg == $past(trap_next_pc))
    else $error("return pc wrong on interrupt");

  cause_flag_a: assert property (
    trap_take |=> cause_irq_reg == $past(trap_is_irq)
      && cause_id_reg == $past(trap_id))
    else $error("cause not loaded from trap");

  cause_reserved_a: assert property (
    csr_valid && csr_addr == mtc_pkg::ADDR_CAUSE
    |=> csr_rdata[30:5] == 26'h000_0000)
    else $error("cause reserved bits not zero");

  value_fetch_a: assert property (
    trap_take && !trap_is_irq && trap_id == mtc_pkg::ID_FETCH_FAULT
    |=> value_reg == $past(trap_fetch_addr))
    else $error("value not fetch address");

  value_ldst_a: assert property (
    trap_take && !trap_is_irq && trap_id == mtc_pkg::ID_STORE_FAULT
    |=> value_reg == $past(trap_pc))
    else $error("value not faulting pc");

  value_illegal_a: assert property (
    trap_take && !trap_is_irq && trap_id == mtc_pkg::ID_ILLEGAL
    |=> value_reg == $past(trap_instr))
    else $error("value not instruction word");

  value_irq_zero_a: assert property (
    trap_take && trap_is_irq |=> value_reg == 32'h0000_0000)
    else $error("value not zero on interrupt");

  value_readonly_a: assert property (
    wr_en && csr_addr == mtc_pkg::ADDR_VALUE && !trap_take
    |=> $stable(value_reg) && !csr_illegal)
    else $error("value changed by software");

  pending_std_a: assert property (
    pending_wr |=> irq_pending[11] == $past(ext_irq)
      && irq_pending[3] == $past(soft_irq))
    else $error("standard pending bit written");

  fast_latch_a: assert property (
    fast_irq != 16'h0000
    |=> (fast_pending & $past(fast_irq)) == $past(fast_irq))
    else $error("fast request lost");

  fast_hold_a: assert property (
    fast_pending[0] && !pending_wr |=> fast_pending[0])
    else $error("fast pending dropped alone");

  timer_follow_a: assert property (
    timer_irq ##1 timer_irq |-> irq_pending[7])
    else $error("timer pending not shown");

  gie_entry_a: assert property (
    trap_take |=> !irq_enable && previous_irq_enable == $past(gie_reg))
    else $error("enable not saved on trap");

  gie_return_a: assert property (
    trap_return && !trap_take |=> irq_enable == $past(pgie_reg))
    else $error("enable not restored on return");

  trap_same_cycle_a: assert property (
    trap_take && csr_valid && csr_addr == mtc_pkg::ADDR_CAUSE
    |=> cause_id_reg == $past(trap_id))
    else $error("software write beat trap entry");

endmodule
`default_nettype wire

//--- mtc_irq_src.sv
// interrupt source model for the peripherals beside the trap unit
`timescale 1ns/10ps
`default_nettype none
module mtc_irq_src (
  // clock
  input wire logic core_clk,
  // requests
  output logic ext_irq,
  output logic timer_irq,
  output logic soft_irq,
  output logic [15:0] fast_irq
);
  initial begin
    ext_irq = 1'b0;
    timer_irq = 1'b0;
    soft_irq = 1'b0;
    fast_irq = 16'h0000;
  end
  // levels held until the source itself drops them
  task automatic set_std(input logic e, input logic t, input logic s);
    @(negedge core_clk);
    ext_irq = e;
    timer_irq = t;
    soft_irq = s;
  endtask
  // new compare value drops the timer request
  task automatic advance_compare();
    @(negedge core_clk);
    timer_irq = 1'b0;
  endtask
  // one-cycle pulse on the chosen fast lines
  task automatic fast_pulse(input logic [15:0] m);
    @(negedge core_clk);
    fast_irq = m;
    @(negedge core_clk);
    fast_irq = 16'h0000;
  endtask
endmodule
`default_nettype wire

//--- mtc_trap_unit_tb.sv
// testbench for the machine trap register unit
`timescale 1ns/10ps
`default_nettype none
module mtc_trap_unit_tb;
  logic core_clk, sys_rst, csr_valid, csr_write, csr_ack, csr_hit;
  logic csr_illegal, trap_take, trap_is_irq, trap_return;
  logic ext_irq, timer_irq, soft_irq, irq_enable, previous_irq_enable;
  logic [11:0] csr_addr;
  logic [31:0] csr_wdata, csr_rdata, irq_pending, trap_return_pc;
  logic [31:0] trap_pc, trap_next_pc, trap_fetch_addr, trap_instr;
  logic [4:0] trap_id;
  logic [15:0] fast_irq;
  logic [2:0] counter_enable;
  logic [11:0] pmc [11] = '{12'hB03, 12'hB1F, 12'hB83, 12'hB9F, 12'hC03,
    12'hC1F, 12'hC83, 12'hC9F, 12'h323, 12'h33F, 12'hB04};
  logic [5:0] tl [12] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05,
    6'h06, 6'h07, 6'h0B, 6'h23, 6'h27, 6'h2B};
  int fails = 0;
  int checks = 0;

  mtc_trap_unit u_dut (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .csr_valid(csr_valid),
    .csr_write(csr_write),
    .csr_addr(csr_addr),
    .csr_wdata(csr_wdata),
    .csr_ack(csr_ack),
    .csr_hit(csr_hit),
    .csr_illegal(csr_illegal),
    .csr_rdata(csr_rdata),
    .trap_take(trap_take),
    .trap_is_irq(trap_is_irq),
    .trap_id(trap_id),
    .trap_pc(trap_pc),
    .trap_next_pc(trap_next_pc),
    .trap_fetch_addr(trap_fetch_addr),
    .trap_instr(trap_instr),
    .trap_return(trap_return),
    .ext_irq(ext_irq),
    .timer_irq(timer_irq),
    .soft_irq(soft_irq),
    .fast_irq(fast_irq),
    .irq_enable(irq_enable),
    .previous_irq_enable(previous_irq_enable),
    .irq_pending(irq_pending),
    .trap_return_pc(trap_return_pc),
    .counter_enable(counter_enable)
  );
  mtc_irq_src u_src (
    .core_clk(core_clk),
    .ext_irq(ext_irq),
    .timer_irq(timer_irq),
    .soft_irq(soft_irq),
    .fast_irq(fast_irq)
  );

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one register access, answer looked at in its ack cycle
  task automatic acc(input logic w, input logic [11:0] a,
    input logic [31:0] d, input logic [31:0] eq, input logic ei,
    input logic eh);
    @(negedge core_clk);
    csr_valid = 1'b1;
    csr_write = w;
    csr_addr = a;
    csr_wdata = d;
    @(negedge core_clk);
    csr_valid = 1'b0;
    chk(32'(csr_ack), 32'h1);
    chk(32'(csr_illegal), 32'(ei));
    chk(32'(csr_hit), 32'(eh));
    if (!w) begin
      chk(csr_rdata, eq);
    end
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] eq);
    acc(1'b0, a, 32'h0, eq, 1'b0, 1'b1);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    acc(1'b1, a, d, 32'h0, 1'b0, 1'b1);
  endtask

  task automatic trap(input logic q, input logic [4:0] i);
    @(negedge core_clk);
    trap_take = 1'b1;
    trap_is_irq = q;
    trap_id = i;
    trap_pc = {16'h1000, 11'h000, i};
    trap_next_pc = {16'h2000, 11'h000, i};
    trap_fetch_addr = {16'h3000, 11'h000, i};
    trap_instr = {16'h4000, 11'h000, i};
    @(negedge core_clk);
    trap_take = 1'b0;
  endtask

  task automatic ret();
    @(negedge core_clk);
    trap_return = 1'b1;
    @(negedge core_clk);
    trap_return = 1'b0;
  endtask

  function automatic logic [31:0] tv(input logic [5:0] t);
    if (t[5]) begin
      return 32'h0000_0000;
    end
    case (t[4:0])
      5'h00, 5'h01: return trap_fetch_addr;
      5'h02: return trap_instr;
      5'h04, 5'h05, 5'h06, 5'h07: return trap_pc;
      default: return 32'h0000_0000;
    endcase
  endfunction

  task automatic end_sim();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    #100000;
    fails++;
    end_sim();
  end

  initial begin
    {sys_rst, csr_valid, csr_write, trap_take, trap_is_irq} = 5'h10;
    trap_return = 1'b0;
    csr_addr = 12'h000;
    csr_wdata = 32'h0;
    trap_id = 5'h00;
    {trap_pc, trap_next_pc, trap_fetch_addr, trap_instr} = 128'h0;
    repeat (16) @(negedge core_clk);
    sys_rst = 1'b0;
    chk(irq_pending, 32'h0);
    chk(32'(counter_enable), 32'h0);
    rd(12'h344, 32'h0);
    rd(12'h310, 32'h0);
    $display("test reset done");
    wr(12'h306, 32'hFFFF_FFFF);
    rd(12'h306, 32'h0000_0007);
    chk(32'(counter_enable), 32'h7);
    foreach (pmc[k]) begin
      acc(1'b0, pmc[k], 32'h0, 32'h0, 1'b1, 1'b1);
    end
    acc(1'b1, 12'hC1F, 32'h1, 32'h0, 1'b1, 1'b1);
    acc(1'b0, 12'h7C0, 32'h0, 32'h0, 1'b0, 1'b0);
    $display("test counter access done");
    wr(12'h310, 32'hFFFF_FFFF);
    rd(12'h310, 32'h0);
    wr(12'h340, 32'hDEAD_BEEF);
    rd(12'h340, 32'hDEAD_BEEF);
    wr(12'h342, 32'hFFFF_FFFF);
    rd(12'h342, 32'h8000_001F);
    $display("test plain registers done");
    foreach (tl[k]) begin
      trap(tl[k][5], tl[k][4:0]);
      chk(trap_return_pc, tl[k][5] ? trap_next_pc : trap_pc);
      rd(12'h341, tl[k][5] ? trap_next_pc : trap_pc);
      rd(12'h342, {tl[k][5], 26'h0, tl[k][4:0]});
      rd(12'h343, tv(tl[k]));
    end
    trap(1'b0, 5'h02);
    wr(12'h343, 32'hA5A5_A5A5);
    rd(12'h343, trap_instr);
    fork
      wr(12'h342, 32'hFFFF_FFFF);
      trap(1'b0, 5'h02);
    join
    rd(12'h342, 32'h0000_0002);
    $display("test trap capture done");
    wr(12'h300, 32'h0000_0008);
    trap(1'b0, 5'h03);
    chk({30'h0, irq_enable, previous_irq_enable}, 32'h1);
    trap(1'b1, 5'h07);
    chk({30'h0, irq_enable, previous_irq_enable}, 32'h0);
    wr(12'h300, 32'h0000_0008);
    trap(1'b0, 5'h02);
    ret();
    chk(32'(irq_enable), 32'h1);
    $display("test enable save done");
    u_src.set_std(1'b1, 1'b1, 1'b1);
    rd(12'h344, 32'h0000_0888);
    wr(12'h344, 32'h0);
    rd(12'h344, 32'h0000_0888);
    u_src.advance_compare();
    rd(12'h344, 32'h0000_0808);
    u_src.set_std(1'b0, 1'b0, 1'b0);
    rd(12'h344, 32'h0);
    u_src.fast_pulse(16'hFFFF);
    rd(12'h344, 32'hFFFF_0000);
    wr(12'h344, 32'hFFFB_FFFF);
    rd(12'h344, 32'hFFFB_0000);
    wr(12'h344, 32'h0);
    rd(12'h344, 32'h0);
    $display("test pending done");
    end_sim();
  end
endmodule
`default_nettype wire
